// File: logic/sfp_pkg.sv
// shared constants and types of the serial mode and control block
// assumes a 16-bit register port with byte offsets on an 8-bit address
package sfp_pkg;

  // register port carrier
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        write;
    logic        read;
  } sfp_bus_req_t;

  // register offsets
  localparam logic [7:0]  MODE_CONFIG_OFS    = 8'h00;
  localparam logic [7:0]  CONTROL_OFS        = 8'h04;

  // field positions
  localparam int unsigned PRESCALE_LO_POS    = 0;
  localparam int unsigned PRESCALE_HI_POS    = 1;
  localparam int unsigned MODE_RSV_POS       = 2;
  localparam int unsigned STOP_POS           = 3;
  localparam int unsigned COMM_MODE_POS      = 7;
  localparam int unsigned RX_ERR_IE_POS      = 10;
  localparam int unsigned TX_STOP_IE_POS     = 11;

  // values after reset and write masks
  localparam logic [15:0] MODE_RESET         = 16'h0000;
  localparam logic [15:0] CONTROL_RESET      = 16'h0000;
  localparam logic [15:0] MODE_WRITE_MASK    = 16'h00fb;
  localparam logic [15:0] MODE_SYNC_KEEP     = 16'h0083;
  localparam logic [15:0] CONTROL_WRITE_MASK = 16'h0fff;

  // prescaler settings and the last count of each division
  typedef enum logic [1:0] {
    PRESCALE_DIV1,
    PRESCALE_DIV4,
    PRESCALE_DIV16,
    PRESCALE_DIV64
  } sfp_prescale_t;
  localparam logic [5:0]  DIV1_LAST          = 6'h00;
  localparam logic [5:0]  DIV4_LAST          = 6'h03;
  localparam logic [5:0]  DIV16_LAST         = 6'h0f;
  localparam logic [5:0]  DIV64_LAST         = 6'h3f;

  // character shape and bit timing
  localparam int unsigned CHAR_BITS          = 8;
  localparam int unsigned TICKS_PER_BIT      = 16;

endpackage : sfp_pkg

// File: logic/sfp_prescaler.sv
// baud clock prescaler: one tick every 1, 4, 16 or 64 clocks
// assumes the select comes from a register on the same clock
`timescale 1ns/1ps
module sfp_prescaler (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // division select
  input  wire logic [1:0] prescale_sel,
  // one-cycle tick
  output logic            tick
);

  logic [5:0] count;
  logic [5:0] last_count;
  wire        at_last;

  // last count of the selected division
  always_comb begin
    case (sfp_pkg::sfp_prescale_t'(prescale_sel))
      sfp_pkg::PRESCALE_DIV1:  last_count = sfp_pkg::DIV1_LAST;
      sfp_pkg::PRESCALE_DIV4:  last_count = sfp_pkg::DIV4_LAST;
      sfp_pkg::PRESCALE_DIV16: last_count = sfp_pkg::DIV16_LAST;
      default:                 last_count = sfp_pkg::DIV64_LAST;
    endcase
  end

  // >= rather than == so a smaller division taken mid-count recovers at once
  assign at_last = (count >= last_count);

  // free-running divider
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count <= 6'h00;
      tick  <= 1'b0;
    end else begin
      tick  <= at_last;
      count <= at_last ? 6'h00 : count + 6'h01;
    end
  end

endmodule : sfp_prescaler

// File: logic/sfp_tx_framer.sv
// transmit framer: data lsb first, with a start bit and one or two stop bits outside synchronous mode
// assumes tick from the prescaler and load data from logic on the same clock
`timescale 1ns/1ps
module sfp_tx_framer #(
  parameter int unsigned TICKS_PER_BIT = sfp_pkg::TICKS_PER_BIT,
  parameter int unsigned CHAR_BITS     = sfp_pkg::CHAR_BITS
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // framing controls
  input  wire logic                 tick,
  input  wire logic                 two_stop,
  input  wire logic                 sync_mode,
  // character load
  input  wire logic [CHAR_BITS-1:0] load_data,
  input  wire logic                 load_valid,
  output logic                      load_ready,
  // serial line
  output logic                      serial_out
);

  localparam int unsigned PW = (TICKS_PER_BIT > 1) ? $clog2(TICKS_PER_BIT) : 1;
  localparam int unsigned BW = (CHAR_BITS > 1) ? $clog2(CHAR_BITS) : 1;
  localparam logic [PW-1:0] LAST_PHASE = PW'(TICKS_PER_BIT - 1);
  localparam logic [BW-1:0] LAST_BIT   = BW'(CHAR_BITS - 1);

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP1, TX_STOP2} sfp_tx_state_t;

  sfp_tx_state_t          state;
  logic [PW-1:0]          phase;
  logic [BW-1:0]          bit_idx;
  logic [CHAR_BITS-1:0]   shift;
  wire                    bit_end;

  assign bit_end = tick && (phase == LAST_PHASE);

  // bit timing restarts with every character
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase <= '0;
    end else if (state == TX_IDLE) begin
      phase <= '0;
    end else if (tick) begin
      phase <= bit_end ? '0 : phase + PW'(1);
    end
  end

  // frame sequencer; the line idles high between characters
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state      <= TX_IDLE;
      bit_idx    <= '0;
      shift      <= '0;
      serial_out <= 1'b1;
      load_ready <= 1'b1;
    end else begin
      case (state)
        TX_IDLE: begin
          serial_out <= 1'b1;
          if (load_valid && load_ready) begin
            shift      <= load_data;
            bit_idx    <= '0;
            load_ready <= 1'b0;
            if (sync_mode) begin
              state      <= TX_DATA;
              serial_out <= load_data[0];
            end else begin
              state      <= TX_START;
              serial_out <= 1'b0;
            end
          end
        end
        TX_START: begin
          if (bit_end) begin
            state      <= TX_DATA;
            serial_out <= shift[0];
          end
        end
        TX_DATA: begin
          if (bit_end) begin
            if (bit_idx == LAST_BIT) begin
              serial_out <= 1'b1;
              if (sync_mode) begin
                state      <= TX_IDLE;
                load_ready <= 1'b1;
              end else begin
                state <= TX_STOP1;
              end
            end else begin
              bit_idx    <= bit_idx + BW'(1);
              shift      <= shift >> 1;
              serial_out <= shift[1];
            end
          end
        end
        TX_STOP1: begin
          if (bit_end) begin
            if (two_stop) begin
              state <= TX_STOP2;
            end else begin
              state      <= TX_IDLE;
              load_ready <= 1'b1;
            end
          end
        end
        TX_STOP2: begin
          if (bit_end) begin
            state      <= TX_IDLE;
            load_ready <= 1'b1;
          end
        end
        default: begin
          state      <= TX_IDLE;
          load_ready <= 1'b1;
          serial_out <= 1'b1;
        end
      endcase
    end
  end

endmodule : sfp_tx_framer

// File: logic/sfp_mode_control.sv
// serial mode and control registers with stop bit framing and interrupt gating
// assumes status flags and fifo stop enable arrive from logic on the same clock,
// and the receive line from a pin outside the clock domain
// the register port never stalls: read data follow a read strobe by one clock
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module sfp_mode_control #(
  parameter int unsigned TICKS_PER_BIT = sfp_pkg::TICKS_PER_BIT,
  parameter int unsigned CHAR_BITS     = sfp_pkg::CHAR_BITS
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // register port
  input  sfp_pkg::sfp_bus_req_t      bus_req,
  output logic [15:0]                read_data,
  // status and fifo control inputs
  input  wire logic                  tx_stop_flag,
  input  wire logic                  tx_stop_enable,
  input  wire logic                  rx_error_flag,
  // transmit character stream
  input  wire logic [CHAR_BITS-1:0]  tx_data,
  input  wire logic                  tx_valid,
  output logic                       tx_ready,
  // receive character stream
  output logic [CHAR_BITS-1:0]       rx_data,
  output logic                       rx_valid,
  output logic                       rx_framing_error,
  // serial pins
  input  wire logic                  rx_pin,
  output logic                       tx_pin,
  // interrupt requests
  output logic                       tx_stop_irq,
  output logic                       rx_error_irq
);

  localparam int unsigned PW = (TICKS_PER_BIT > 1) ? $clog2(TICKS_PER_BIT) : 1;
  localparam int unsigned BW = (CHAR_BITS > 1) ? $clog2(CHAR_BITS) : 1;
  localparam logic [PW-1:0] LAST_PHASE = PW'(TICKS_PER_BIT - 1);
  localparam logic [PW-1:0] MID_PHASE  = PW'(TICKS_PER_BIT / 2 - 1);
  localparam logic [BW-1:0] LAST_BIT   = BW'(CHAR_BITS - 1);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sfp_rx_state_t;

  // registers
  logic [15:0]           serial_mode_config;
  logic [15:0]           serial_control;

  // register port decode
  wire                   hit_mode;
  wire                   hit_control;
  wire                   write_mode;
  wire                   write_control;
  wire [15:0]            mode_masked;
  wire [15:0]            next_mode;
  wire [15:0]            next_control;
  wire [15:0]            next_read_data;

  // read path
  wire                   read_mode;
  wire                   read_control;
  wire [15:0]            read_mode_value;
  wire [15:0]            read_control_value;

  // mode fields seen by the data path, control enables and next requests
  wire                   sync_mode;
  wire                   two_stop;
  wire [1:0]             prescale_sel;
  wire                   prescale_sel_hi;
  wire                   prescale_sel_lo;
  wire                   tx_stop_irq_en;
  wire                   rx_error_irq_en;
  wire                   next_tx_stop_irq;
  wire                   next_rx_error_irq;

  // baud tick
  logic                  tick;

  // receive path
  logic                  rx_sync1;
  logic                  rx_line;
  sfp_rx_state_t         rx_state;
  logic [PW-1:0]         rx_phase;
  logic [BW-1:0]         rx_bit_idx;
  logic [CHAR_BITS-1:0]  rx_shift;
  wire                   rx_mid;
  wire                   rx_bit_end;
  wire                   rx_start_seen;
  wire                   rx_glitch;
  wire                   rx_last_bit;
  wire                   rx_stop_low;

  // address decode; strobes are never both high in one cycle
  assign hit_mode      = (bus_req.addr == sfp_pkg::MODE_CONFIG_OFS);
  assign hit_control   = (bus_req.addr == sfp_pkg::CONTROL_OFS);
  assign write_mode    = bus_req.write && hit_mode;
  assign write_control = bus_req.write && hit_control;

  // reserved bit dropped on the way in, so it can never read back as one
  assign mode_masked = bus_req.wdata & sfp_pkg::MODE_WRITE_MASK;
  // choosing synchronous mode keeps only its own bit and the prescaler
  assign next_mode = bus_req.wdata[sfp_pkg::COMM_MODE_POS]
                   ? (mode_masked & sfp_pkg::MODE_SYNC_KEEP)
                   : mode_masked;
  assign next_control = bus_req.wdata & sfp_pkg::CONTROL_WRITE_MASK;

  // read decode; reserved bits are masked again on the way out as well
  assign read_mode          = bus_req.read && hit_mode;
  assign read_control       = bus_req.read && hit_control;
  assign read_mode_value    = serial_mode_config & sfp_pkg::MODE_WRITE_MASK;
  assign read_control_value = serial_control & sfp_pkg::CONTROL_WRITE_MASK;

  // read mux; an unmapped address or no strobe reads as zero
  assign next_read_data = read_mode    ? read_mode_value
                        : read_control ? read_control_value
                        : 16'h0000;

  // mode register; writes pass the reserved and synchronous masks first
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      serial_mode_config <= sfp_pkg::MODE_RESET;
    end else if (write_mode) begin
      serial_mode_config <= next_mode;
    end
  end

  // control register; both request enables come out of reset cleared
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      serial_control <= sfp_pkg::CONTROL_RESET;
    end else if (write_control) begin
      serial_control <= next_control;
    end
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      read_data <= 16'h0000;
    end else begin
      read_data <= next_read_data;
    end
  end

  // field extraction
  assign sync_mode       = serial_mode_config[sfp_pkg::COMM_MODE_POS];
  // stop length ignored in synchronous mode even if stored
  assign two_stop        = serial_mode_config[sfp_pkg::STOP_POS] && !sync_mode;
  assign prescale_sel_hi = serial_mode_config[sfp_pkg::PRESCALE_HI_POS];
  assign prescale_sel_lo = serial_mode_config[sfp_pkg::PRESCALE_LO_POS];
  assign prescale_sel    = {prescale_sel_hi, prescale_sel_lo};
  assign tx_stop_irq_en  = serial_control[sfp_pkg::TX_STOP_IE_POS];
  assign rx_error_irq_en = serial_control[sfp_pkg::RX_ERR_IE_POS];

  // requests follow their flag and enable, the stop request also the fifo stop enable; clearing any withdraws them
  assign next_tx_stop_irq  = tx_stop_irq_en && tx_stop_enable && tx_stop_flag;
  assign next_rx_error_irq = rx_error_irq_en && rx_error_flag;

  // registered so the outputs are glitch free, at one clock of lag
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_stop_irq <= 1'b0;
    end else begin
      tx_stop_irq <= next_tx_stop_irq;
    end
  end

  // same lag on the error request, so both follow their inputs alike
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_error_irq <= 1'b0;
    end else begin
      rx_error_irq <= next_rx_error_irq;
    end
  end

  // baud clock from the peripheral clock
  sfp_prescaler u_prescaler (
    .clock        (clock),
    .reset        (reset),
    .prescale_sel (prescale_sel),
    .tick         (tick)
  );

  // transmit framing
  sfp_tx_framer #(
    .TICKS_PER_BIT (TICKS_PER_BIT),
    .CHAR_BITS     (CHAR_BITS)
  ) u_tx_framer (
    .clock      (clock),
    .reset      (reset),
    .tick       (tick),
    .two_stop   (two_stop),
    .sync_mode  (sync_mode),
    .load_data  (tx_data),
    .load_valid (tx_valid),
    .load_ready (tx_ready),
    .serial_out (tx_pin)
  );

  // two flops bring the receive pin into the clock domain
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_sync1 <= 1'b1;
      rx_line  <= 1'b1;
    end else begin
      rx_sync1 <= rx_pin;
      rx_line  <= rx_sync1;
    end
  end

  assign rx_mid     = tick && (rx_phase == MID_PHASE);
  assign rx_bit_end = tick && (rx_phase == LAST_PHASE);

  // receive decode; a start is only looked for on a tick, and one that has
  // gone again by mid-bit was a glitch on the line
  assign rx_start_seen = !sync_mode && tick && !rx_line;
  assign rx_glitch     = rx_mid && rx_line;
  assign rx_last_bit   = (rx_bit_idx == LAST_BIT);
  assign rx_stop_low   = !rx_line;

  // receive bit timing; rearmed in idle so a start edge sets the phase
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_phase <= '0;
    end else if (rx_state == RX_IDLE) begin
      rx_phase <= '0;
    end else if (rx_state == RX_START && rx_mid) begin
      rx_phase <= '0;
    end else if (tick) begin
      rx_phase <= rx_bit_end ? '0 : rx_phase + PW'(1);
    end
  end

  // asynchronous receiver; after the first stop it returns to idle at once,
  // so a second stop that is high is idle line and one that is low starts a
  // new character. synchronous reception needs the serial clock, not here.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_state         <= RX_IDLE;
      rx_bit_idx       <= '0;
      rx_shift         <= '0;
      rx_data          <= '0;
      rx_valid         <= 1'b0;
      rx_framing_error <= 1'b0;
    end else begin
      rx_valid         <= 1'b0;
      rx_framing_error <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (rx_start_seen) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_mid) begin
            // a start that is gone by mid-bit was a glitch
            rx_state   <= rx_glitch ? RX_IDLE : RX_DATA;
            rx_bit_idx <= '0;
          end
        end
        RX_DATA: begin
          if (rx_bit_end) begin
            rx_shift <= {rx_line, rx_shift[CHAR_BITS-1:1]};
            if (rx_last_bit) begin
              rx_state <= RX_STOP;
            end else begin
              rx_bit_idx <= rx_bit_idx + BW'(1);
            end
          end
        end
        RX_STOP: begin
          if (rx_bit_end) begin
            rx_state         <= RX_IDLE;
            rx_data          <= rx_shift;
            rx_valid         <= 1'b1;
            rx_framing_error <= rx_stop_low;
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

endmodule : sfp_mode_control

// File: bench/sfp_mode_control_assertions.sv
// checker for the serial mode and control block
// assumes it is bound into sfp_mode_control and sees only its ports
`timescale 1ns/1ps
module sfp_mode_control_checker (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   reset,
  // register port
  input wire sfp_pkg::sfp_bus_req_t  bus_req,
  input wire logic [15:0]            read_data,
  // flags
  input wire logic                   tx_stop_flag,
  input wire logic                   tx_stop_enable,
  input wire logic                   rx_error_flag,
  // transmit side
  input wire logic                   tx_valid,
  input wire logic                   tx_ready,
  input wire logic                   tx_pin,
  // receive side and requests
  input wire logic                   rx_valid,
  input wire logic                   rx_framing_error,
  input wire logic                   tx_stop_irq,
  input wire logic                   rx_error_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // bus decode
  logic stop_ie;
  logic err_ie;
  logic sync;
  wire  at_mode = bus_req.addr == sfp_pkg::MODE_CONFIG_OFS;
  wire  at_ctl  = bus_req.addr == sfp_pkg::CONTROL_OFS;
  wire  rd_mode = bus_req.read && at_mode;
  wire  rd_ctl  = bus_req.read && at_ctl;
  wire  rd_none = bus_req.read && !at_mode && !at_ctl;
  // shadow of enables and sync bit, rebuilt from writes so the irq check is independent
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      {stop_ie, err_ie, sync} <= 3'b000;
    end else begin
      if (bus_req.write && at_ctl) {stop_ie, err_ie} <= bus_req.wdata[11:10];
      if (bus_req.write && at_mode) sync <= bus_req.wdata[7];
    end
  end
  sequence s_load;
    tx_valid && tx_ready && !sync;
  endsequence
  a_start_bit: assert property (s_load |=> !tx_pin && !tx_ready)
    else $error("no start bit after load");
  a_idle_high: assert property (tx_ready && !sync |-> tx_pin)
    else $error("line not high while idle");
  a_stop_irq: assert property (tx_stop_irq == $past(stop_ie && tx_stop_enable && tx_stop_flag))
    else $error("stop request wrong");
  a_err_irq: assert property (rx_error_irq == $past(err_ie && rx_error_flag))
    else $error("error request wrong");
  a_read_idle: assert property (!$past(bus_req.read) |-> read_data == 16'h0000)
    else $error("read data outside read cycle");
  a_mode_rsv: assert property ($past(rd_mode) |-> read_data[15:8] == 8'h00 && !read_data[2])
    else $error("mode reserved bits not zero");
  a_sync_force: assert property ($past(rd_mode && sync) |-> (read_data & 16'hff7c) == 16'h0000)
    else $error("sync mode bits not cleared");
  a_ctl_rsv: assert property ($past(rd_ctl) |-> read_data[15:12] == 4'h0)
    else $error("control reserved bits not zero");
  a_ctl_enables: assert property ($past(rd_ctl) |-> read_data[11:10] == $past({stop_ie, err_ie}))
    else $error("enables read back wrong");
  a_unmapped_zero: assert property ($past(rd_none) |-> read_data == 16'h0000)
    else $error("unmapped read not zero");
  a_error_pair: assert property (rx_framing_error |-> rx_valid)
    else $error("framing error without character");
endmodule : sfp_mode_control_checker

bind sfp_mode_control sfp_mode_control_checker u_chk (
  .clock(clock), .reset(reset), .bus_req(bus_req), .read_data(read_data),
  .tx_stop_flag(tx_stop_flag), .tx_stop_enable(tx_stop_enable),
  .rx_error_flag(rx_error_flag), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_pin(tx_pin), .rx_valid(rx_valid), .rx_framing_error(rx_framing_error),
  .tx_stop_irq(tx_stop_irq), .rx_error_irq(rx_error_irq)
);

// File: bench/sfp_uart_peer.sv
// behavioural remote transmitter driving the block's receive pin
// assumes send is called right after a rising clock edge
`timescale 1ns/1ps
module sfp_uart_peer #(
  parameter int BIT_CLOCKS = 32
) (
  // clock
  input  wire logic clock,
  // serial line, idle high
  output logic      line
);
  initial line = 1'b1;
  // start, data lsb first, stops; first stop may be forced low to make a framing fault
  task automatic send(input logic [7:0] d, input int stops, input logic first_stop);
    logic [11:0] f;
    f = {2'b11, first_stop, d, 1'b0};
    @(posedge clock);
    for (int i = 0; i < 9 + stops; i++) begin
      line <= f[i];
      repeat (BIT_CLOCKS) @(posedge clock);
    end
    // back to idle high, so a low stop is not read as a further start
    line <= 1'b1;
  endtask : send
endmodule : sfp_uart_peer

// File: bench/sfp_mode_control_test.sv
// self-checking bench for the serial mode and control block
// assumes package, design, peer model and checker are compiled before it
`timescale 1ns/1ps
module sfp_mode_control_test;
  localparam int TPB = 8;
  logic                  clock = 1'b0;
  logic                  reset = 1'b1;
  sfp_pkg::sfp_bus_req_t bus_req = '0;
  logic [15:0]           read_data;
  logic                  tx_stop_flag = 1'b0;
  logic                  tx_stop_enable = 1'b0;
  logic                  rx_error_flag = 1'b0;
  logic [7:0]            tx_data = 8'h00;
  logic                  tx_valid = 1'b0;
  logic [7:0]            rx_data;
  logic                  tx_ready, rx_valid, rx_framing_error, rx_pin, tx_pin;
  logic                  tx_stop_irq, rx_error_irq;
  logic [15:0]           mode_m = 16'h0000;
  logic [15:0]           ctrl_m = 16'h0000;
  logic [8:0]            rx_q[$];
  logic [8:0]            ex_q[$];
  logic                  bit_q[$];
  int                    miscompares = 0;
  int                    checked = 0;

  sfp_mode_control #(.TICKS_PER_BIT(TPB)) u_dut (
    .clock(clock), .reset(reset), .bus_req(bus_req), .read_data(read_data),
    .tx_stop_flag(tx_stop_flag), .tx_stop_enable(tx_stop_enable),
    .rx_error_flag(rx_error_flag), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_framing_error(rx_framing_error), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .tx_stop_irq(tx_stop_irq), .rx_error_irq(rx_error_irq));
  // receive line partner at prescale 01, four clocks per tick
  sfp_uart_peer #(.BIT_CLOCKS(TPB * 4)) u_peer (.clock(clock), .line(rx_pin));

  always #12.5 clock = ~clock;
  // collect every received character with its error mark
  always @(posedge clock) if (rx_valid === 1'b1) rx_q.push_back({rx_framing_error, rx_data});

  task automatic summarize();
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  // register write; the model keeps only what the device may store
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.write <= 1'b1;
    @(posedge clock);
    bus_req.write <= 1'b0;
    if (a == 8'h00) mode_m = d[7] ? d & 16'h0083 : d & 16'h00fb;
    if (a == 8'h04) ctrl_m = d & 16'h0fff;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic [15:0] exp;
    exp = a == 8'h00 ? mode_m : a == 8'h04 ? ctrl_m : 16'h0000;
    @(posedge clock);
    bus_req.addr <= a;
    bus_req.read <= 1'b1;
    @(posedge clock);
    bus_req.read <= 1'b0;
    #1 chk(read_data, exp);
  endtask : rd

  // one character out; reserved bit 2 is written high on purpose
  task automatic tx_frame(input int ps, input logic two, input logic sy, input logic [7:0] d);
    int b;
    int n;
    int c;
    b = TPB << (2 * ps);
    wr(8'h00, {8'h00, sy, 3'b101, two, 1'b1, ps[1:0]});
    rd(8'h00);
    bit_q.delete();
    if (!sy) bit_q.push_back(1'b0);
    for (int i = 0; i < 8; i++) bit_q.push_back(d[i]);
    if (!sy) bit_q.push_back(1'b1);
    if (!sy && two) bit_q.push_back(1'b1);
    n = bit_q.size();
    @(posedge clock);
    tx_data <= d;
    tx_valid <= 1'b1;
    @(posedge clock);
    tx_valid <= 1'b0;
    #1 c = 0;
    while (tx_ready !== 1'b1 && c <= n * b + 1) begin
      @(posedge clock);
      #1 c++;
      if ((c - 1) % b == b / 2 && (c - 1) / b < n) chk(tx_pin, bit_q[(c - 1) / b]);
    end
    // first bit may be short by one tick of the free-running prescaler
    chk(16'(c > n * b - (b / TPB) && c <= n * b + 1), 16'h0001);
  endtask : tx_frame

  initial begin
    logic [31:0] r;
    logic [7:0]  d;
    void'($urandom(26));
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    rd(8'h00);
    rd(8'h04);
    // random writes, reserved bits and unmapped offsets included
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      wr({4'h0, r[3:2], 2'b00}, r[31:16]);
      rd({4'h0, r[3:2], 2'b00});
    end
    // requests follow enable AND flag, set and withdrawn at random
    for (int i = 0; i < 48; i++) begin
      r = $urandom;
      @(posedge clock);
      tx_stop_flag <= r[0];
      tx_stop_enable <= r[1];
      rx_error_flag <= r[2];
      wr(8'h04, {4'h0, r[3], r[4], r[15:6]});
      @(posedge clock);
      #1 chk(tx_stop_irq, r[3] & r[1] & r[0]);
      chk(rx_error_irq, r[4] & r[2]);
    end
    for (int ps = 0; ps < 4; ps++) begin
      for (int t = 0; t < 2; t++) tx_frame(ps, t[0], 1'b0, 8'($urandom));
    end
    tx_frame(1, 1'b1, 1'b1, 8'($urandom));
    // two stops set; peer sends two, then one stop with the next start right behind
    wr(8'h00, 16'h0009);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      ex_q.push_back({i == 3, d});
      u_peer.send(d, i == 0 ? 2 : 1, i != 3);
    end
    repeat (TPB * 4 * 3) @(posedge clock);
    chk(16'(rx_q.size() == 4), 16'h0001);
    for (int i = 0; i < 4 && i < rx_q.size(); i++) chk({7'h00, rx_q[i]}, {7'h00, ex_q[i]});
    // second reset mid-run puts both registers back to zero
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    mode_m = 16'h0000;
    ctrl_m = 16'h0000;
    rd(8'h00);
    rd(8'h04);
    summarize();
  end

  // watchdog well above the roughly sixteen thousand cycles the run needs
  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    summarize();
  end
endmodule : sfp_mode_control_test
